// >>> design/tws_ctrl.sv
// Write-start control of one tape synchronizer: buffer clear, first loads, gap delay, start.
`timescale 1ns/10ps
`include "tws_map.svh"

// Overview of operation
// - Write-ready sets only with buffer-ready, program start and tape-ready (or first block) all set.
// - Write preset request sets the preset flag, which arms the buffer clear.
// - Buffer clear sets at a slot strobe during timing-on, resets at next strobe.
// - A preset in a lower-numbered synchronizer blocks our buffer clear.
// - Buffer clear never starts or ends inside any tape-write cycle.
// - Clear end gives clear-done, first word request, and first-word-requested flag.
// - Word-loaded acknowledge gives second word request and sets buffer-ready.
// - Tape start strobe launches 8.7 ms or 22.7 ms delay per gap mode.
// - Delay expiry sets tape-ready unless starting from first block.
// - First block with bad spot seen holds off the write start.
// - Start pulse sets write-ready and clears start, buffer-ready, tape-ready, inhibit.
// - Start pulse lasts 0.5 us, ended by its own counter; its write-ready output blocks a retrigger.
// - Inhibit suppresses write operate; gap controls set and clear it.
// - Bad-spot controls set inhibit during the spot and clear it afterwards.
// - Write halt sets inhibit; write end resets write-ready.
// - Setup with gap digit 0 selects short gap; write end resets it.
module tws_ctrl
  import tws_pkg::*;
#(
  parameter int CNT_W        = `TWS_DELAY_CNT_W,
  parameter int SHORT_CYCLES = (`TWS_SHORT_GAP_NS + `TWS_CLK_PERIOD_NS - 1) / `TWS_CLK_PERIOD_NS,
  parameter int LONG_CYCLES  = (`TWS_LONG_GAP_NS + `TWS_CLK_PERIOD_NS - 1) / `TWS_CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Register port.
  input  wire logic [`TWS_ADDR_W-1:0]  reg_addr,
  input  wire logic [`TWS_DATA_W-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`TWS_DATA_W-1:0]  reg_rdata,
  // Tape unit control and timing pins.
  input  wire logic                    write_preset_request,
  input  wire logic                    tape_start_strobe,
  input  wire logic                    first_block_flag,
  input  wire logic                    timing_slot_strobe,
  input  wire logic                    tape_timing_on,
  input  wire logic                    buffer_step_timing,
  input  wire logic                    any_write_cycle,
  input  wire logic                    lower_preset_block,
  // Dispatcher handshake.
  input  wire logic                    word_loaded_ack,
  output logic                         clear_done_strobe,
  output logic                         first_word_request,
  output logic                         second_word_request,
  // Gap, bad-spot and ending controls.
  input  wire logic                    bad_spot_seen,
  input  wire logic                    gap_inhibit_set,
  input  wire logic                    gap_inhibit_clear,
  input  wire logic                    badspot_inhibit_set,
  input  wire logic                    badspot_inhibit_clear,
  input  wire logic                    write_halt,
  input  wire logic                    write_end_strobe,
  // Outputs to the buffers, the other synchronizers and the write circuits.
  output logic                         buffer_clear_active,
  output logic                         buffer_clear_step,
  output logic                         write_preset_out,
  output logic                         short_gap_select,
  output logic                         long_gap_select,
  output logic                         start_condition_pulse,
  output logic                         write_active,
  output logic                         write_operate
);

  localparam int PULSE_CYCLES =
    (`TWS_START_PULSE_NS + `TWS_CLK_PERIOD_NS - 1) / `TWS_CLK_PERIOD_NS;
  localparam int NPIN = 15;
  localparam logic [4:0] PULSE_LAST = 5'(PULSE_CYCLES - 1);

  // Pin positions in the synchroniser bank.
  localparam int P_PRESET = 0;
  localparam int P_TSTART = 1;
  localparam int P_FBLK   = 2;
  localparam int P_TSS    = 3;
  localparam int P_TON    = 4;
  localparam int P_STEP   = 5;
  localparam int P_WCYC   = 6;
  localparam int P_BLOCK  = 7;
  localparam int P_ACK    = 8;
  localparam int P_BSPOT  = 9;
  localparam int P_GSET   = 10;
  localparam int P_GCLR   = 11;
  localparam int P_BSET   = 12;
  localparam int P_BCLR   = 13;
  localparam int P_HALT   = 14;

  typedef struct packed {
    tws_buf_state_type       buf_state;
    logic [NPIN-1:0]         pin_prev;
    logic                    end_prev;
    logic                    tape_ready;
    logic                    rw_start;
    logic                    write_ready;
    logic                    inhibit;
    logic                    gap_short;
    logic [4:0]              pulse_cnt;
    logic                    start_pulse;
    logic                    write_operate;
    logic                    clear_done;
    logic                    first_req;
    logic                    second_req;
    logic                    clear_step;
    logic                    clear_active;
    logic                    preset_out;
    logic                    long_gap;
    logic [`TWS_DATA_W-1:0]  rdata;
  } tws_ctrl_state_type;

  tws_ctrl_state_type state_ff;
  tws_ctrl_state_type nxt_state;

  logic [NPIN-1:0]  pin_sync;
  logic [NPIN-1:0]  pin_rise;
  logic             end_sync;
  logic             delay_busy;
  logic             delay_expired;
  logic             delay_trigger;
  logic [CNT_W-1:0] delay_length;
  logic             start_cond;
  logic             preset_flag;
  logic             clearing;
  logic [`TWS_DATA_W-1:0] status_word;

  tws_sync #(
    .WIDTH (NPIN)
  ) u_pin_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({write_halt, badspot_inhibit_clear, badspot_inhibit_set, gap_inhibit_clear,
                gap_inhibit_set, bad_spot_seen, word_loaded_ack, lower_preset_block,
                any_write_cycle, buffer_step_timing, tape_timing_on, timing_slot_strobe,
                first_block_flag, tape_start_strobe, write_preset_request}),
    .sync_out (pin_sync)
  );

  // The write end strobe gets its own stage so that it can also restart the gap mode.
  tws_sync #(
    .WIDTH (1)
  ) u_end_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (write_end_strobe),
    .sync_out (end_sync)
  );

  // Strobes from the tape unit are long compared with the clock, so act on their rising edge.
  assign pin_rise = pin_sync & ~state_ff.pin_prev;

  assign preset_flag = (state_ff.buf_state != TWS_BUF_IDLE) &&
                       (state_ff.buf_state != TWS_BUF_READY);
  assign clearing    = (state_ff.buf_state == TWS_BUF_CLEAR);

  assign delay_trigger = pin_rise[P_TSTART];
  assign delay_length  = state_ff.gap_short ? CNT_W'(SHORT_CYCLES) : CNT_W'(LONG_CYCLES);

  tws_delay #(
    .CNT_W (CNT_W)
  ) u_gap_delay (
    .clk     (clk),
    .reset   (reset),
    .trigger (delay_trigger),
    .length  (delay_length),
    .abandon (1'b0),
    .busy    (delay_busy),
    .expired (delay_expired)
  );

  // From the first block the tape-ready flag never sets, so the late program start alone,
  // together with the buffers, opens the write; a passing bad spot holds it shut.
  assign start_cond = (state_ff.buf_state == TWS_BUF_READY) && state_ff.rw_start &&
                      (state_ff.tape_ready || pin_sync[P_FBLK]) &&
                      !(pin_sync[P_FBLK] && pin_sync[P_BSPOT]) &&
                      !state_ff.write_ready && !state_ff.start_pulse;

  always_comb begin
    status_word = `TWS_STATUS_RST;
    status_word[`TWS_ST_PRESET_BIT]   = preset_flag;
    status_word[`TWS_ST_CLEAR_BIT]    = clearing;
    status_word[`TWS_ST_FWREQ_BIT]    = (state_ff.buf_state == TWS_BUF_FWREQ);
    status_word[`TWS_ST_OBR_BIT]      = (state_ff.buf_state == TWS_BUF_READY);
    status_word[`TWS_ST_TREADY_BIT]   = state_ff.tape_ready;
    status_word[`TWS_ST_RWSTART_BIT]  = state_ff.rw_start;
    status_word[`TWS_ST_WREADY_BIT]   = state_ff.write_ready;
    status_word[`TWS_ST_INHIBIT_BIT]  = state_ff.inhibit;
    status_word[`TWS_ST_SHORTGAP_BIT] = state_ff.gap_short;
    status_word[`TWS_ST_DELAY_BIT]    = delay_busy;
  end

  always_comb begin
    nxt_state            = state_ff;
    nxt_state.pin_prev   = pin_sync;
    nxt_state.end_prev   = end_sync;
    nxt_state.clear_done = 1'b0;
    nxt_state.first_req  = 1'b0;
    nxt_state.second_req = 1'b0;
    nxt_state.rdata      = '0;

    // Buffer clear and initial loading.
    case (state_ff.buf_state)
      TWS_BUF_IDLE: begin
        if (pin_rise[P_PRESET]) begin
          nxt_state.buf_state = TWS_BUF_ARMED;
        end
      end
      TWS_BUF_ARMED: begin
        // Slot strobes fall between write cycles; the explicit check keeps that true here.
        if (pin_rise[P_TSS] && pin_sync[P_TON] && !pin_sync[P_BLOCK] &&
            !pin_sync[P_WCYC]) begin
          nxt_state.buf_state = TWS_BUF_CLEAR;
        end
      end
      TWS_BUF_CLEAR: begin
        if (pin_rise[P_TSS] && !pin_sync[P_WCYC]) begin
          nxt_state.buf_state  = TWS_BUF_FWREQ;
          nxt_state.clear_done = 1'b1;
          nxt_state.first_req  = 1'b1;
        end
      end
      TWS_BUF_FWREQ: begin
        if (pin_rise[P_ACK]) begin
          nxt_state.buf_state  = TWS_BUF_READY;
          nxt_state.second_req = 1'b1;
        end
      end
      TWS_BUF_READY: begin
        if (start_cond) begin
          nxt_state.buf_state = TWS_BUF_IDLE;
        end
      end
      default: begin
        nxt_state.buf_state = TWS_BUF_IDLE;
      end
    endcase

    nxt_state.clear_step = (nxt_state.buf_state == TWS_BUF_CLEAR) && pin_sync[P_STEP];
    nxt_state.clear_active = (nxt_state.buf_state == TWS_BUF_CLEAR);
    nxt_state.preset_out   = (nxt_state.buf_state != TWS_BUF_IDLE) &&
                             (nxt_state.buf_state != TWS_BUF_READY);

    // Tape acceleration delay result.
    if (delay_expired && !pin_sync[P_FBLK]) begin
      nxt_state.tape_ready = 1'b1;
    end

    // Program instructions through the control register.
    if (reg_wr && reg_addr == `TWS_CTRL_OFS) begin
      if (reg_wdata[`TWS_CTRL_START_BIT]) begin
        nxt_state.rw_start = 1'b1;
      end
      if (reg_wdata[`TWS_CTRL_SETUP_BIT] && !reg_wdata[`TWS_CTRL_GAPDIG_BIT]) begin
        nxt_state.gap_short = 1'b1;
      end
    end

    // Single pulser: write-ready, once set, closes the gate that made the pulse.
    if (start_cond) begin
      nxt_state.start_pulse = 1'b1;
      nxt_state.write_ready = 1'b1;
      nxt_state.pulse_cnt   = '0;
      nxt_state.rw_start    = 1'b0;
      nxt_state.tape_ready  = 1'b0;
    end else if (state_ff.start_pulse) begin
      if (state_ff.pulse_cnt == PULSE_LAST) begin
        nxt_state.start_pulse = 1'b0;
      end else begin
        nxt_state.pulse_cnt = state_ff.pulse_cnt + 5'h01;
      end
    end

    // Inhibit write: a set arriving with any clear wins.
    if (start_cond || pin_rise[P_GCLR] || pin_rise[P_BCLR]) begin
      nxt_state.inhibit = 1'b0;
    end
    if (pin_rise[P_GSET] || pin_rise[P_BSET] || pin_rise[P_HALT]) begin
      nxt_state.inhibit = 1'b1;
    end

    // Write end closes the operation and returns the gap mode to long.
    if (end_sync && !state_ff.end_prev) begin
      nxt_state.write_ready = 1'b0;
      nxt_state.gap_short   = 1'b0;
    end

    nxt_state.write_operate = nxt_state.write_ready && !nxt_state.inhibit;
    nxt_state.long_gap      = !nxt_state.gap_short;

    if (reg_rd) begin
      case (reg_addr)
        `TWS_STATUS_OFS: nxt_state.rdata = status_word;
        default:         nxt_state.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff           <= '0;
      state_ff.gap_short <= `TWS_GAP_SHORT_RST;
      state_ff.long_gap  <= !`TWS_GAP_SHORT_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata             = state_ff.rdata;
  assign clear_done_strobe     = state_ff.clear_done;
  assign first_word_request    = state_ff.first_req;
  assign second_word_request   = state_ff.second_req;
  assign buffer_clear_active   = state_ff.clear_active;
  assign buffer_clear_step     = state_ff.clear_step;
  assign write_preset_out      = state_ff.preset_out;
  assign short_gap_select      = state_ff.gap_short;
  assign long_gap_select       = state_ff.long_gap;
  assign start_condition_pulse = state_ff.start_pulse;
  assign write_active          = state_ff.write_ready;
  assign write_operate         = state_ff.write_operate;

  default clocking tws_cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence clear_finish_s;
    clear_done_strobe && first_word_request && !buffer_clear_active;
  endsequence

  clear_entry_a: assert property ($rose(buffer_clear_active) |->
      $past(!pin_sync[P_BLOCK] && pin_sync[P_TON] && !pin_sync[P_WCYC]))
    else $error("buffer clear began while blocked or outside timing-on");
  clear_done_a: assert property ($fell(buffer_clear_active) |-> clear_finish_s)
    else $error("clear end without clear-done and first word request");
  clear_window_a: assert property (buffer_clear_step |-> buffer_clear_active)
    else $error("buffer step outside the clear cycle");
  second_req_a: assert property (second_word_request |->
      $past(state_ff.buf_state == TWS_BUF_FWREQ) && status_word[`TWS_ST_OBR_BIT])
    else $error("second word request without buffer-ready");
  start_gate_a: assert property ($rose(write_active) |->
      $past(status_word[`TWS_ST_OBR_BIT] && state_ff.rw_start) && start_condition_pulse)
    else $error("write-ready set without its start conditions");
  start_clears_a: assert property ($rose(start_condition_pulse) |->
      !state_ff.rw_start && !state_ff.tape_ready && !state_ff.inhibit)
    else $error("start pulse left a start flag set");
  pulse_width_a: assert property ($rose(start_condition_pulse) |->
      start_condition_pulse[*8] ##1 start_condition_pulse[*8] ##1
      start_condition_pulse[*8] ##1 start_condition_pulse ##1 !start_condition_pulse)
    else $error("start pulse width is not 0.5 us");
  tape_ready_a: assert property ($rose(state_ff.tape_ready) |->
      $past(delay_expired && !pin_sync[P_FBLK]))
    else $error("tape-ready set without delay expiry or during first block");
  operate_inhibit_a: assert property (state_ff.inhibit |-> !write_operate)
    else $error("write operate present while inhibited");
  end_stops_a: assert property ((end_sync && !state_ff.end_prev) |=>
      !write_active && !short_gap_select)
    else $error("write end left write-ready or short gap set");

endmodule : tws_ctrl

// >>> common/tws_map.svh
// Register offsets, field positions, reset values and timing constants of the write-start block.
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// Register byte offsets on the plain register port.
`define TWS_CTRL_OFS        4'h0
`define TWS_STATUS_OFS      4'h4
`define TWS_ADDR_W          4
`define TWS_DATA_W          32

// Control register fields (write only, every bit self-clearing).
`define TWS_CTRL_START_BIT  0
`define TWS_CTRL_SETUP_BIT  1
`define TWS_CTRL_GAPDIG_BIT 2

// Status register fields.
`define TWS_ST_PRESET_BIT   0
`define TWS_ST_CLEAR_BIT    1
`define TWS_ST_FWREQ_BIT    2
`define TWS_ST_OBR_BIT      3
`define TWS_ST_TREADY_BIT   4
`define TWS_ST_RWSTART_BIT  5
`define TWS_ST_WREADY_BIT   6
`define TWS_ST_INHIBIT_BIT  7
`define TWS_ST_SHORTGAP_BIT 8
`define TWS_ST_DELAY_BIT    9

// Reset values.
`define TWS_STATUS_RST      32'h0000_0000
`define TWS_GAP_SHORT_RST   1'b0

// Timing, in nanoseconds, and the clock period.
`define TWS_CLK_PERIOD_NS   20
`define TWS_SHORT_GAP_NS    8700000
`define TWS_LONG_GAP_NS     22700000
`define TWS_START_PULSE_NS  500
`define TWS_DELAY_CNT_W     21

`endif

// >>> common/tws_pkg.sv
// Types shared by the write-start block.
package tws_pkg;

  // Buffer preparation sequence, Gray coded from idle up to ready; the return to idle flips two bits.
  typedef enum logic [2:0] {
    TWS_BUF_IDLE  = 3'h0,
    TWS_BUF_ARMED = 3'h1,
    TWS_BUF_CLEAR = 3'h3,
    TWS_BUF_FWREQ = 3'h2,
    TWS_BUF_READY = 3'h6
  } tws_buf_state_type;

endpackage : tws_pkg

// >>> design/tws_sync.sv
// Two-flop synchroniser bank for the asynchronous pins of the write-start block.
`timescale 1ns/10ps
module tws_sync
  import tws_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset,
  // Pins in and synchronised levels out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } tws_sync_state_type;

  tws_sync_state_type state_ff;
  tws_sync_state_type nxt_state;

  // The first stage feeds only the second one.
  always_comb begin
    nxt_state = state_ff;
    for (int i = 0; i < WIDTH; i++) begin
      nxt_state.meta[i]   = async_in[i];
      nxt_state.stable[i] = state_ff.meta[i];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stable;

endmodule : tws_sync

// >>> design/tws_delay.sv
// Retriggerable delay element used for the tape acceleration delay.
`timescale 1ns/10ps
`include "tws_map.svh"
module tws_delay
  import tws_pkg::*;
#(
  parameter int CNT_W = `TWS_DELAY_CNT_W
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset,
  // Trigger with its length, abandon, and results.
  input  wire logic             trigger,
  input  wire logic [CNT_W-1:0] length,
  input  wire logic             abandon,
  output logic                  busy,
  output logic                  expired
);

  typedef struct packed {
    logic             busy;
    logic             expired;
    logic [CNT_W-1:0] count;
  } tws_delay_state_type;

  tws_delay_state_type state_ff;
  tws_delay_state_type nxt_state;

  // A trigger while running restarts the delay from its full length.
  always_comb begin
    nxt_state         = state_ff;
    nxt_state.expired = 1'b0;
    if (abandon) begin
      nxt_state.busy  = 1'b0;
      nxt_state.count = '0;
    end else if (trigger) begin
      nxt_state.busy  = 1'b1;
      nxt_state.count = length;
    end else if (state_ff.busy) begin
      if (state_ff.count <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
        nxt_state.busy    = 1'b0;
        nxt_state.expired = 1'b1;
        nxt_state.count   = '0;
      end else begin
        nxt_state.count = state_ff.count - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign busy    = state_ff.busy;
  assign expired = state_ff.expired;

endmodule : tws_delay

// >>> tb/tws_disp_model.sv
// Behavioural memory dispatcher that loads the first output word on request.
`timescale 1ns/10ps
module tws_disp_model #(
  parameter int DLY = 5
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Word requests and load acknowledge.
  input  wire logic first_word_request,
  input  wire logic second_word_request,
  output logic      word_loaded_ack
);
  int cnt_ff;
  // The acknowledge is held until the second request, so a slow load is still seen.
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff          <= 0;
      word_loaded_ack <= 1'b0;
    end else if (first_word_request) begin
      cnt_ff <= DLY;
    end else if (cnt_ff == 1) begin
      cnt_ff          <= 0;
      word_loaded_ack <= 1'b1;
    end else begin
      if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
      if (second_word_request) word_loaded_ack <= 1'b0;
    end
  end
endmodule : tws_disp_model

// >>> tb/tb_tws_ctrl.sv
// Self-checking testbench of the write-start control.
`timescale 1ns/10ps
`include "tws_map.svh"
module tb_tws_ctrl;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, st;
  logic [8:0]  pins = 9'h0;
  logic        first_block_flag = 1'b0, tape_timing_on = 1'b1, buffer_step_timing = 1'b1;
  logic        any_write_cycle = 1'b0, lower_preset_block = 1'b0, bad_spot_seen = 1'b0;
  logic        word_loaded_ack, clear_done_strobe, first_word_request, second_word_request;
  logic        buffer_clear_active, buffer_clear_step, write_preset_out, short_gap_select;
  logic        long_gap_select, start_condition_pulse, write_active, write_operate;
  logic [4:0]  outs;
  int          n_errors = 0, cmp_count = 0, cyc = 0, n;

  assign outs = {start_condition_pulse, second_word_request, first_word_request,
                 buffer_clear_active, write_preset_out};
  always #10 clk = ~clk;

  tws_ctrl #(.SHORT_CYCLES(40), .LONG_CYCLES(100)) i_dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .write_preset_request(pins[0]), .tape_start_strobe(pins[1]),
    .first_block_flag(first_block_flag), .timing_slot_strobe(pins[2]),
    .tape_timing_on(tape_timing_on), .buffer_step_timing(buffer_step_timing),
    .any_write_cycle(any_write_cycle), .lower_preset_block(lower_preset_block),
    .word_loaded_ack(word_loaded_ack), .clear_done_strobe(clear_done_strobe),
    .first_word_request(first_word_request), .second_word_request(second_word_request),
    .bad_spot_seen(bad_spot_seen), .gap_inhibit_set(pins[3]), .gap_inhibit_clear(pins[4]),
    .badspot_inhibit_set(pins[5]), .badspot_inhibit_clear(pins[6]),
    .write_halt(pins[7]), .write_end_strobe(pins[8]),
    .buffer_clear_active(buffer_clear_active), .buffer_clear_step(buffer_clear_step),
    .write_preset_out(write_preset_out), .short_gap_select(short_gap_select),
    .long_gap_select(long_gap_select), .start_condition_pulse(start_condition_pulse),
    .write_active(write_active), .write_operate(write_operate));

  tws_disp_model #(.DLY(5)) i_disp (
    .clk(clk), .reset(reset), .first_word_request(first_word_request),
    .second_word_request(second_word_request), .word_loaded_ack(word_loaded_ack));

  task test_done;
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // The status word is captured one cycle after the read strobe.
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask : rd

  // Pins pass two flops and an edge detector, so eight cycles cover the full response.
  task pin(input int i);
    @(posedge clk);
    pins[i] <= 1'b1;
    repeat (4) @(posedge clk);
    pins[i] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pin

  task wt(input int i);
    for (int k = 0; k < 20 && !outs[i]; k++) begin
      @(posedge clk);
      #1;
    end
    chk(outs[i], 1'b1);
  endtask : wt

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1 chk({write_active, start_condition_pulse, short_gap_select, long_gap_select}, 4'h1);
    rd(`TWS_STATUS_OFS);
    chk(st, `TWS_STATUS_RST);
    rd(4'hC);
    chk(st, 32'h0);
    wr(`TWS_CTRL_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk({short_gap_select, long_gap_select}, 2'h2);
    pin(0);
    chk(write_preset_out, 1'b1);
    lower_preset_block <= 1'b1;
    pin(2);
    chk(buffer_clear_active, 1'b0);
    lower_preset_block <= 1'b0;
    any_write_cycle    <= 1'b1;
    pin(2);
    chk(buffer_clear_active, 1'b0);
    any_write_cycle <= 1'b0;
    pin(2);
    chk(buffer_clear_active, 1'b1);
    chk(buffer_clear_step, buffer_step_timing);
    fork
      pin(2);
      begin
        wt(2);
        chk(clear_done_strobe, 1'b1);
      end
    join
    chk(buffer_clear_active, 1'b0);
    wt(3);
    chk(write_preset_out, 1'b0);
    rd(`TWS_STATUS_OFS);
    chk(st[3:0], 4'h8);
    pin(1);
    repeat (25) @(posedge clk);
    rd(`TWS_STATUS_OFS);
    chk({st[9], st[4]}, 2'h2);
    repeat (20) @(posedge clk);
    rd(`TWS_STATUS_OFS);
    chk({st[9], st[4], st[6]}, 3'h2);
    wr(`TWS_CTRL_OFS, 32'h1);
    wt(4);
    n = 1;
    for (int k = 0; k < 60 && start_condition_pulse; k++) begin
      @(posedge clk);
      #1 n += start_condition_pulse;
    end
    chk(n, 25);
    chk({write_active, write_operate}, 2'h3);
    rd(`TWS_STATUS_OFS);
    chk(st[7:3], 5'h08);
    for (int i = 3; i < 8; i++) begin
      pin(i);
      chk(write_operate, !i[0]);
    end
    pin(8);
    chk({write_active, short_gap_select, long_gap_select}, 3'h1);
    // Second write starts from the first block with a bad spot passing the head.
    first_block_flag <= 1'b1;
    bad_spot_seen    <= 1'b1;
    pin(0);
    pin(2);
    fork
      pin(2);
      wt(2);
    join
    wt(3);
    pin(1);
    repeat (110) @(posedge clk);
    rd(`TWS_STATUS_OFS);
    chk({st[9], st[4]}, 2'h0);
    wr(`TWS_CTRL_OFS, 32'h1);
    repeat (8) @(posedge clk);
    chk(write_active, 1'b0);
    bad_spot_seen <= 1'b0;
    wt(4);
    chk(write_active, 1'b1);
    test_done();
  end
endmodule : tb_tws_ctrl
